//--- rtl/alu_if.sv
`timescale 1ns/1ps
// operands into and result out of the arithmetic unit
interface alu_if;
  import fpcmd_pkg::*;
  alu_op_t op;  // operation
  logic dbl;    // 1 double, 0 single
  dword_t a;    // memory operand
  dword_t b;    // register operand
  dword_t c;    // accumulator for multiply-add
  dword_t res;  // result
  logic lt;     // compare: less than
  logic eq;     // compare: equal
  logic gt;     // compare: greater than
  modport user(output op, dbl, a, b, c, input res, lt, eq, gt);
  modport unit(input op, dbl, a, b, c, output res, lt, eq, gt);
endinterface

//--- rtl/fp_arith.sv
`timescale 1ns/1ps
// combinational datapath; values are two's-complement fixed point
module fp_arith (
  alu_if.unit u
);
  import fpcmd_pkg::*;

  logic signed [63:0] ax;   // operand a at working width
  logic signed [63:0] bx;   // operand b at working width
  logic signed [63:0] r;    // raw result
  logic signed [63:0] lhs;  // compare left side
  logic signed [63:0] rhs;  // compare right side
  logic narrow;             // result is kept at 32 bits

  // ----------------------------------------------------------------
  // operation select
  // ----------------------------------------------------------------
  always_comb begin
    // single values live in the low word and are sign-extended here
    ax = u.dbl ? signed'(u.a) : signed'({{32{u.a[31]}}, u.a[31:0]});
    bx = u.dbl ? signed'(u.b) : signed'({{32{u.b[31]}}, u.b[31:0]});
    r = ax;
    lhs = ax;
    rhs = 64'sh0;
    narrow = ~u.dbl;
    unique case (u.op)
      OP_NEG: r = -ax;
      OP_ABS: r = ax[63] ? -ax : ax;
      OP_ITOF: r = signed'({{32{u.a[31]}}, u.a[31:0]});
      OP_FTOI: begin
        // source is at the given precision, result is a 32-bit integer
        r = ax;
        narrow = 1'b1;
      end
      OP_CVT: begin
        // dbl names the target: single to double, or double to single
        r = u.dbl ? signed'({{32{u.a[31]}}, u.a[31:0]}) : signed'(u.a);
      end
      OP_SQR: r = ax * ax;
      OP_SUB: r = bx - ax;
      OP_ADD: r = bx + ax;
      OP_MUL: r = bx * ax;
      OP_RSUB: r = ax - bx;
      OP_TST: begin
        lhs = ax;
        rhs = 64'sh0;
      end
      OP_CMP: begin
        lhs = bx;
        rhs = ax;
      end
      OP_MCMP: begin
        // magnitudes; the most negative value stays negative, a known limit
        lhs = bx[63] ? -bx : bx;
        rhs = ax[63] ? -ax : ax;
      end
      OP_MOV: r = ax;
      OP_MAC: r = signed'(u.c) + ax * bx;
      OP_NOP: r = bx;
    endcase
  end

  // ----------------------------------------------------------------
  // result width and compare flags
  // ----------------------------------------------------------------
  always_comb begin
    u.res = narrow ? {32'h0, r[31:0]} : dword_t'(r);
    u.lt = lhs < rhs;
    u.eq = lhs == rhs;
    u.gt = lhs > rhs;
  end

endmodule

//--- rtl/fp_cmd_decode.sv
`timescale 1ns/1ps
// Overview of operation
// R1: only address nibble E selects this device
// R2: command fields come from address bits 12:2
// R3: read or write chosen by read line only
// R4: host puts zero in address bits 27:16
// R5: host drives unused command bits as zero
// R6: low address 0x0C04 loads register 0 low word
// R7: register ram: 01100, register, word select
// R8: short command computes into selected register
// R9: short fields: format, opcode, register, precision
// R10: short add to register 5 sums into it
// R11: double short first write carries high half
// R12: second write at 0x1000 completes double operand
// R13: host reads result back from register ram
// R14: conversions, negate, absolute, square both precisions
// R15: memory and register operands in either position
// R16: test against zero, compare value or magnitude
// R17: dot product over consecutive register pairs
// R18: matrix move and transpose 2x2 to 4x4
// R19: host writes and reads data registers
// R20: mode and status registers read and write
// R21: other nibbles ignored, no answer, no change
// R22: double short waits for its low half
module fp_cmd_decode #(
  parameter int REG_COUNT = 32
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic ACC_STB,
  input wire logic RD_NWR,
  input wire fpcmd_pkg::word_t ADDR,
  input wire fpcmd_pkg::word_t WDATA,
  output logic ACK,
  output fpcmd_pkg::word_t RDATA,
  output logic BUSY,
  output logic PENDING,
  output fpcmd_pkg::mode_t MODE_BITS,
  output logic [2:0] CMP_FLAGS
);
  import fpcmd_pkg::*;

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  // register indices are five bits wide and wrap at the array end
  if (REG_COUNT != 32) begin : g_bad_count
    $error("REG_COUNT must be 32");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_MULTI, ST_HOLD} state_t;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic rst_m_r;              // reset release, first stage
  logic rst_n_r;              // reset release, used everywhere
  logic stb_s1;               // strobe sync, first stage
  logic stb_s2;               // strobe sync, second stage
  logic stb_s3;               // delayed copy for the edge
  logic rw_s1;                // read line sync stages
  logic rw_s2;
  word_t addr_s1;             // address sync stages
  word_t addr_s2;
  word_t wd_s1;               // data sync stages
  word_t wd_s2;
  logic stb_rise;             // new access seen
  state_t state_r;            // access sequencer
  dword_t float_data_reg [REG_COUNT];  // register ram
  mode_t mode_r;              // arithmetic mode register
  word_t status_r;            // arithmetic status register
  logic pend_r;               // double short first half held
  word_t pend_hi_r;           // its high operand word
  alu_op_t pend_op_r;         // its operation
  logic [3:0] pend_reg_r;     // its register
  logic [1:0] mk_r;           // multi-register kind
  logic [2:0] mn_r;           // matrix side or term count
  logic mdbl_r;               // multi-register precision
  logic [4:0] msrc_r;         // first source register
  logic [4:0] msrc2_r;        // second source register (dot)
  logic [4:0] mdst_r;         // destination register
  logic [1:0] row_r;          // row or term index
  logic [1:0] col_r;          // column index
  dword_t acc_r;              // dot product running sum
  logic hit;                  // address carries our nibble
  logic is_wr;                // access is a write
  logic is_ram;               // register ram access
  logic is_ctl;               // mode or status access
  logic is_multi;             // multi-register command
  logic is_short;             // short command, first write
  logic is_second;            // double short second write
  alu_op_t sh_op;             // short opcode field
  logic [3:0] sh_reg;         // short register field
  logic sh_dbl;               // short precision field
  logic [3:0] ram_reg;        // register ram select
  logic [1:0] ram_word;       // register ram word select
  logic take;                 // an access to us is taken now
  logic exec_now;             // a short command runs now
  logic [3:0] ex_reg;         // register a short command hits
  logic writes_reg;           // operation stores a result
  logic [2:0] msize;          // decoded matrix size
  logic [4:0] lin_idx;        // row-major element index
  logic [4:0] tr_idx;         // column-major element index
  logic [4:0] rd_idx;         // register read in a multi step
  logic [4:0] wr_idx;         // register written in a multi step
  logic m_last;               // final step of a multi command
  logic m_go;                 // multi-register write that runs

  alu_if au();

  fp_arith u_arith (
    .u (au)
  );

  // ----------------------------------------------------------------
  // reset release and input synchronisers
  // ----------------------------------------------------------------
  // reset asserts at once and is released two edges later
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_m_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_n_r <= rst_m_r;
    end
  end

  // the backplane is asynchronous: every pin passes two flops.
  // address and data are held by the host while the strobe is high,
  // so they settle in the sync stages before the strobe edge does.
  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      stb_s1 <= 1'b0;
      stb_s2 <= 1'b0;
      stb_s3 <= 1'b0;
      rw_s1 <= 1'b0;
      rw_s2 <= 1'b0;
      addr_s1 <= 32'h0;
      addr_s2 <= 32'h0;
      wd_s1 <= 32'h0;
      wd_s2 <= 32'h0;
    end else begin
      stb_s1 <= ACC_STB;
      stb_s2 <= stb_s1;
      stb_s3 <= stb_s2;
      rw_s1 <= RD_NWR;
      rw_s2 <= rw_s1;
      addr_s1 <= ADDR;
      addr_s2 <= addr_s1;
      wd_s1 <= WDATA;
      wd_s2 <= wd_s1;
    end
  end

  assign stb_rise = stb_s2 & ~stb_s3;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // bits 27:13 and 1:0 are never looked at; the host zeroes them
  always_comb begin
    hit = addr_s2[SEL_HI:SEL_LO] == DEV_NIBBLE;  // R1 R21 R4
    is_wr = ~rw_s2;                               // R3
    is_ram = addr_s2[12:8] == FMT_REGRAM;         // R7 R2
    is_ctl = addr_s2[12:8] == FMT_CTRL;
    is_multi = addr_s2[12:8] == FMT_MULTI;
    is_short = addr_s2[12:11] == FMT_SHORT;       // R9
    is_second = addr_s2[12:2] == SECOND_HALF;     // R12 R5
    sh_op = addr_s2[10:7];                        // R9
    sh_reg = addr_s2[6:3];
    sh_dbl = addr_s2[2];
    ram_reg = addr_s2[7:4];                       // R7
    ram_word = addr_s2[3:2];
    msize = 3'(addr_s2[7:6]) + 3'd2;              // R18
  end

  // accesses outside our nibble never leave idle and get no answer
  assign take = (state_r == ST_IDLE) && stb_rise && hit;  // R21

  // size 11 or kind 11 is an unknown format: answered, nothing runs,
  // since a side of five would never reach its last step
  assign m_go = take && is_wr && is_multi &&
                addr_s2[7:6] != 2'h3 && addr_s2[5:4] != 2'h3;  // R18

  // a single short runs on its only write, a double one on its second
  assign exec_now = take && is_wr &&
                    ((is_short && !sh_dbl) || (is_second && pend_r));  // R8 R22
  assign ex_reg = is_second ? pend_reg_r : sh_reg;
  assign writes_reg = (au.op != OP_TST) && (au.op != OP_CMP) &&
                      (au.op != OP_MCMP) && (au.op != OP_NOP);

  // ----------------------------------------------------------------
  // multi-register step indexing
  // ----------------------------------------------------------------
  always_comb begin
    lin_idx = 5'(row_r * mn_r) + 5'(col_r);
    tr_idx = 5'(col_r * mn_r) + 5'(row_r);
    rd_idx = msrc_r + ((mk_r == MK_TRAN) ? tr_idx : lin_idx);  // R18
    wr_idx = mdst_r + lin_idx;
    if (mk_r == MK_DOT) begin
      m_last = 3'(row_r) == mn_r - 3'd1;                      // R17
      rd_idx = msrc_r + 5'(row_r);
    end else begin
      m_last = (3'(row_r) == mn_r - 3'd1) && (3'(col_r) == mn_r - 3'd1);
    end
  end

  // ----------------------------------------------------------------
  // arithmetic unit operands
  // ----------------------------------------------------------------
  // in short commands the memory operand is the a side, the register the b side,
  // so both operand positions of the instruction map onto one unit
  always_comb begin
    if (state_r == ST_MULTI) begin
      au.op = (mk_r == MK_DOT) ? OP_MAC : OP_MOV;             // R17
      au.dbl = mdbl_r;
      au.a = float_data_reg[rd_idx];
      au.b = float_data_reg[msrc2_r + 5'(row_r)];
      au.c = acc_r;
    end else begin
      au.op = is_second ? pend_op_r : sh_op;                  // R9 R14
      au.dbl = is_second ? 1'b1 : sh_dbl;
      au.a = is_second ? {pend_hi_r, wd_s2} : {32'h0, wd_s2}; // R12 R15
      au.b = float_data_reg[5'(ex_reg)];
      au.c = 64'h0;
    end
  end

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  // the answer is held until the host drops its strobe
  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (take) begin
            // a multi-register write runs first, then answers
            if (m_go) begin
              state_r <= ST_MULTI;
            end else begin
              state_r <= ST_HOLD;
            end
          end
        end
        ST_MULTI: begin
          if (m_last) begin
            state_r <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (!stb_s2) begin
            state_r <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // multi-register command registers
  // ----------------------------------------------------------------
  // data word: 4:0 first source, 9:5 second source, 14:10 destination
  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      mk_r <= MK_MOVE;
      mn_r <= 3'd2;
      mdbl_r <= 1'b0;
      msrc_r <= 5'h0;
      msrc2_r <= 5'h0;
      mdst_r <= 5'h0;
      row_r <= 2'h0;
      col_r <= 2'h0;
      acc_r <= 64'h0;
    end else if (state_r == ST_IDLE) begin
      if (m_go) begin
        mk_r <= addr_s2[5:4];
        mn_r <= msize;
        mdbl_r <= addr_s2[2];
        msrc_r <= wd_s2[4:0];
        msrc2_r <= wd_s2[9:5];
        mdst_r <= wd_s2[14:10];
        row_r <= 2'h0;
        col_r <= 2'h0;
        acc_r <= 64'h0;
      end
    end else if (state_r == ST_MULTI) begin
      acc_r <= au.res;                                        // R17
      if (mk_r == MK_DOT || 3'(col_r) == mn_r - 3'd1) begin
        col_r <= 2'h0;
        row_r <= row_r + 2'h1;
      end else begin
        col_r <= col_r + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // pending double short command
  // ----------------------------------------------------------------
  // a new first half replaces an unfinished one; the completing
  // second half clears it, other accesses leave it alone
  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pend_r <= 1'b0;
      pend_hi_r <= 32'h0;
      pend_op_r <= OP_NOP;
      pend_reg_r <= 4'h0;
    end else if (take && is_wr) begin
      if (is_short && sh_dbl) begin
        pend_r <= 1'b1;                                       // R11 R22
        pend_hi_r <= wd_s2;
        pend_op_r <= sh_op;
        pend_reg_r <= sh_reg;
      end else if (is_second) begin
        pend_r <= 1'b0;                                       // R12
      end
    end
  end

  // ----------------------------------------------------------------
  // register ram write port
  // ----------------------------------------------------------------
  // no reset: contents are undefined until software loads them.
  // an in-place transpose overwrites elements it still has to read,
  // so source and destination blocks must not overlap.
  always_ff @(posedge CLK) begin
    if (state_r == ST_MULTI) begin
      if (mk_r != MK_DOT) begin
        float_data_reg[wr_idx] <= au.res;                     // R18
      end else if (m_last) begin
        float_data_reg[mdst_r] <= au.res;                     // R17
      end
    end else if (exec_now && writes_reg) begin
      float_data_reg[5'(ex_reg)] <= au.res;                   // R8 R10 R14
    end else if (take && is_wr && is_ram) begin
      if (ram_word == WSEL_LSW) begin
        float_data_reg[5'(ram_reg)][31:0] <= wd_s2;           // R6 R19
      end else if (ram_word == WSEL_MSW) begin
        float_data_reg[5'(ram_reg)][63:32] <= wd_s2;          // R19
      end
    end
  end

  // ----------------------------------------------------------------
  // mode and status registers
  // ----------------------------------------------------------------
  // compares land in status; a host write in the same cycle is
  // impossible since one access is handled at a time
  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      mode_r <= MODE_RST;
      status_r <= STATUS_RST;
    end else if (exec_now && !writes_reg && au.op != OP_NOP) begin
      status_r[ST_EQ] <= au.eq;                               // R16
      status_r[ST_LT] <= au.lt;
      status_r[ST_GT] <= au.gt;
    end else if (take && is_wr && is_ctl) begin
      if (addr_s2[2]) begin
        status_r <= wd_s2;                                    // R20
      end else begin
        mode_r <= wd_s2[3:0];                                 // R20
      end
    end
  end

  // ----------------------------------------------------------------
  // answer and read data
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ACK <= 1'b0;
      RDATA <= 32'h0;
    end else begin
      if (state_r == ST_HOLD && !stb_s2) begin
        ACK <= 1'b0;
      end else if ((take && !m_go) ||
                   (state_r == ST_MULTI && m_last)) begin
        ACK <= 1'b1;
      end
      if (take && !is_wr) begin
        // unmapped reads answer with zero
        if (is_ram && ram_word == WSEL_LSW) begin
          RDATA <= float_data_reg[5'(ram_reg)][31:0];         // R19 R13
        end else if (is_ram && ram_word == WSEL_MSW) begin
          RDATA <= float_data_reg[5'(ram_reg)][63:32];        // R19
        end else if (is_ctl) begin
          RDATA <= addr_s2[2] ? status_r : {28'h0, mode_r};   // R20
        end else begin
          RDATA <= 32'h0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      BUSY <= 1'b0;
      PENDING <= 1'b0;
      MODE_BITS <= MODE_RST;
      CMP_FLAGS <= 3'h0;
    end else begin
      BUSY <= state_r == ST_MULTI;
      PENDING <= pend_r;
      MODE_BITS <= mode_r;
      CMP_FLAGS <= status_r[2:0];
    end
  end

endmodule

//--- rtl/fpcmd_pkg.sv
package fpcmd_pkg;

  // ----------------------------------------------------------------
  // data widths and types
  // ----------------------------------------------------------------
  typedef logic [31:0] word_t;   // one bus word
  typedef logic [63:0] dword_t;  // one data register, double wide
  typedef logic [3:0] alu_op_t;  // arithmetic operation code
  typedef logic [3:0] mode_t;    // arithmetic mode bits

  // ----------------------------------------------------------------
  // address decode: select nibble and command fields
  // ----------------------------------------------------------------
  localparam logic [3:0] DEV_NIBBLE = 4'he;      // addr 31:28 value
  localparam int SEL_HI = 31;                    // select nibble msb
  localparam int SEL_LO = 28;                    // select nibble lsb
  localparam logic [4:0] FMT_REGRAM = 5'h0c;     // 12:8 = 01100
  localparam logic [4:0] FMT_CTRL = 5'h0d;       // 12:8 = 01101
  localparam logic [4:0] FMT_MULTI = 5'h0e;      // 12:8 = 01110
  localparam logic [1:0] FMT_SHORT = 2'h0;       // 12:11 = 00
  localparam logic [10:0] SECOND_HALF = 11'h400; // 12:2 of low 0x1000
  localparam logic [1:0] WSEL_LSW = 2'h1;        // register ram low word
  localparam logic [1:0] WSEL_MSW = 2'h0;        // register ram high word
  localparam logic [1:0] MK_MOVE = 2'h0;         // matrix move
  localparam logic [1:0] MK_TRAN = 2'h1;         // matrix transpose
  localparam logic [1:0] MK_DOT = 2'h2;          // dot product

  // ----------------------------------------------------------------
  // operation codes (short format bits 10:7)
  // ----------------------------------------------------------------
  localparam alu_op_t OP_NEG = 4'h0;
  localparam alu_op_t OP_ABS = 4'h1;
  localparam alu_op_t OP_ITOF = 4'h2;
  localparam alu_op_t OP_FTOI = 4'h3;
  localparam alu_op_t OP_CVT = 4'h4;
  localparam alu_op_t OP_SQR = 4'h5;
  localparam alu_op_t OP_SUB = 4'h6;
  localparam alu_op_t OP_ADD = 4'h7;
  localparam alu_op_t OP_MUL = 4'h8;
  localparam alu_op_t OP_RSUB = 4'h9;
  localparam alu_op_t OP_TST = 4'ha;
  localparam alu_op_t OP_CMP = 4'hb;
  localparam alu_op_t OP_MCMP = 4'hc;
  localparam alu_op_t OP_MOV = 4'hd;
  localparam alu_op_t OP_MAC = 4'he;
  localparam alu_op_t OP_NOP = 4'hf;

  // ----------------------------------------------------------------
  // reset values and status layout
  // ----------------------------------------------------------------
  localparam mode_t MODE_RST = 4'h2;
  localparam word_t STATUS_RST = 32'h0;
  localparam int ST_EQ = 0;  // status bit: equal
  localparam int ST_LT = 1;  // status bit: less than
  localparam int ST_GT = 2;  // status bit: greater than

endpackage

//--- sim/fp_cmd_decode_properties.sv
`timescale 1ns/1ps
// port-level timing and side effects of the decoder
module fp_cmd_decode_properties (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic ACC_STB,
  input wire logic RD_NWR,
  input wire fpcmd_pkg::word_t ADDR,
  input wire logic ACK,
  input wire fpcmd_pkg::word_t RDATA,
  input wire logic BUSY,
  input wire logic PENDING,
  input wire fpcmd_pkg::mode_t MODE_BITS
);
  import fpcmd_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  property p_ack_cause;
    $rose(ACK) |-> $past(ACC_STB, 2) && $past(ADDR[31:28], 2) == DEV_NIBBLE;
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack cause");
  property p_ack_lat;
    $rose(ACC_STB) && ADDR[31:28] == DEV_NIBBLE && ADDR[12:8] != FMT_MULTI |-> ##[3:5] ACK;
  endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack late");
  property p_ign;
    ACC_STB && ADDR[31:28] != DEV_NIBBLE |-> !ACK;
  endproperty
  a_ign: assert property (p_ign) else $error("foreign ack");
  property p_rdata;
    $changed(RDATA) |-> $past(ACC_STB && RD_NWR);
  endproperty
  a_rdata: assert property (p_rdata) else $error("rdata moved");
  property p_pend_set;
    $rose(PENDING) |-> $past(ACC_STB && !RD_NWR && ADDR[12:11] == FMT_SHORT && ADDR[2]);
  endproperty
  a_pend_set: assert property (p_pend_set) else $error("pending set");
  property p_pend_clr;
    $fell(PENDING) |-> $past(ACC_STB && !RD_NWR && ADDR[12:2] == SECOND_HALF);
  endproperty
  a_pend_clr: assert property (p_pend_clr) else $error("pending clear");
  property p_mode;
    $changed(MODE_BITS) |-> $past(ACC_STB && !RD_NWR && ADDR[12:8] == FMT_CTRL && !ADDR[2], 2);
  endproperty
  a_mode: assert property (p_mode) else $error("mode moved");
  property p_busy;
    $rose(BUSY) |-> $past(ACC_STB && ADDR[12:8] == FMT_MULTI);
  endproperty
  a_busy: assert property (p_busy) else $error("busy cause");
  c_pend: cover property ($rose(PENDING));
  c_busy: cover property ($rose(BUSY));
  c_read: cover property ($rose(ACK) && RD_NWR);
endmodule
bind fp_cmd_decode fp_cmd_decode_properties chk_u (.CLK(CLK), .RST_N(RST_N), .ACC_STB(ACC_STB),
  .RD_NWR(RD_NWR), .ADDR(ADDR), .ACK(ACK), .RDATA(RDATA), .BUSY(BUSY), .PENDING(PENDING),
  .MODE_BITS(MODE_BITS));

//--- sim/fp_cmd_decode_tb.sv
`timescale 1ns/1ps
module fp_cmd_decode_tb;
  import fpcmd_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ack, busy, pend, stb, rd;
  word_t addr, wdata, rdata, a, b, v;
  mode_t mode;
  logic [2:0] flags;
  word_t exp_q[$];
  alu_op_t ops[4] = '{OP_NEG, OP_ABS, OP_SQR, OP_MOV};
  int n_errors = 0;
  int checks = 0;
  int n_busy = 0;
  always #25 clk = ~clk;
  always @(posedge busy) n_busy++;
  fp_cmd_decode dut_u (.CLK(clk), .RST_N(rst_n), .ACC_STB(stb), .RD_NWR(rd), .ADDR(addr),
    .WDATA(wdata), .ACK(ack), .RDATA(rdata), .BUSY(busy), .PENDING(pend), .MODE_BITS(mode),
    .CMP_FLAGS(flags));
  fp_host h (.clk(clk), .ack(ack), .stb(stb), .rd(rd), .addr(addr), .wdata(wdata));
  task automatic chk(input string s, input word_t e, input word_t g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] lo, input word_t d);
    h.acc(1'b0, lo, d);
  endtask
  task automatic rdx(input logic [15:0] lo, input word_t e);
    exp_q.push_back(e);
    h.acc(1'b1, lo, 32'h0);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // read data is matched against the oldest expectation
  always @(posedge ack) begin
    #1;
    if (rd === 1'b1)
      chk("rdata", exp_q.pop_front(), rdata);
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    summarize();
  end
  initial begin
    void'($urandom(32'hd0ad));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("mode", {28'h0, MODE_RST}, {28'h0, mode});
    a = $urandom;
    wr(16'h0c04, a);
    wr(16'h0c00, 32'h0);
    rdx(16'h0c04, a);
    rdx(16'h0c00, 32'h0);
    $display("regram done");
    a = $urandom_range(1 << 20);
    b = $urandom_range(1 << 20);
    wr(16'h0c54, a);
    wr(16'h0c50, 32'h0);
    wr(16'h03a8, b);
    rdx(16'h0c54, a + b);
    rdx(16'h0c50, 32'h0);
    wr(16'h03ac, 32'h1);
    chk("pend", 32'h1, {31'h0, pend});
    rdx(16'h0c54, a + b);
    v = $urandom_range(1 << 20);
    wr(16'h1000, v);
    chk("pend", 32'h0, {31'h0, pend});
    rdx(16'h0c54, a + b + v);
    rdx(16'h0c50, 32'h1);
    h.acc(1'b0, 16'h0c54, 32'h0, 4'hd);
    rdx(16'h0c54, a + b + v);
    $display("short done");
    foreach (ops[i]) begin
      v = $urandom_range(1000);
      wr({5'h0, ops[i], 4'h3, 3'h0}, ops[i] == OP_ABS ? -v : v);
      rdx(16'h0c34, ops[i] == OP_NEG ? -v : ops[i] == OP_SQR ? v * v : v);
    end
    wr(16'h0d00, 32'h5);
    chk("mode", 32'h5, {28'h0, mode});
    rdx(16'h0d00, 32'h5);
    wr(16'h0d04, 32'h6);
    rdx(16'h0d04, 32'h6);
    chk("flags", 32'h6, {29'h0, flags});
    $display("ops done");
    for (int i = 0; i < 4; i++)
      wr({8'h0c, 4'(8 + i), 4'h4}, 32'(i + 2));
    wr(16'h0e20, 32'h3148);
    rdx(16'h0cc4, 32'd23);
    wr(16'h0e00, 32'h3008);
    rdx(16'h0cd4, 32'd3);
    wr(16'h0e10, 32'h3008);
    rdx(16'h0cd4, 32'd4);
    rdx(16'h0ce4, 32'd3);
    wr(16'h0ee0, 32'h3148);
    rdx(16'h0cc4, 32'd2);
    wr({5'h0, OP_CMP, 4'h8, 3'h0}, -32'd5);
    chk("flags", 32'h4, {29'h0, flags});
    wr({5'h0, OP_MCMP, 4'h8, 3'h0}, -32'd5);
    chk("flags", 32'h2, {29'h0, flags});
    wr({5'h0, OP_TST, 4'h8, 3'h0}, 32'h0);
    chk("flags", 32'h1, {29'h0, flags});
    chk("busy runs", 32'd3, n_busy);
    chk("no ack", 32'd1, h.n_noack);
    chk("reads left", 32'd0, exp_q.size());
    $display("multi done");
    summarize();
  end
endmodule

//--- sim/fp_host.sv
`timescale 1ns/1ps
// host bus master: holds every qualifier until ack is sampled
module fp_host (
  input wire logic clk,
  input wire logic ack,
  output logic stb,
  output logic rd,
  output fpcmd_pkg::word_t addr,
  output fpcmd_pkg::word_t wdata
);
  import fpcmd_pkg::*;
  int n_noack = 0;  // accesses that timed out with no ack
  initial begin
    stb = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = '0;
  end
  // one access; a foreign nibble gets no ack, so the host gives up
  task automatic acc(input logic r, input logic [15:0] lo, input word_t d,
                     input logic [3:0] nib = 4'he);
    int n;
    n = 0;
    @(posedge clk);
    stb <= 1'b1;
    rd <= r;
    addr <= {nib, 12'h0, lo};
    wdata <= d;
    while (ack !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (ack !== 1'b1)
      n_noack++;
    repeat ($urandom_range(2)) @(posedge clk);
    stb <= 1'b0;
    wdata <= ~d;
    while (ack !== 1'b0) @(posedge clk);
  endtask
endmodule
